//--- hdl/dcc_pkg.sv
/*
 * shared constants, carrier types and helpers for the dispatch and completion control.
 * assumes a single clock domain and in-core synchronous neighbours.
 */
`default_nettype none

package dcc_pkg;

	localparam int DCC_DISP_W = 2;
	localparam int DCC_CQ_DEPTH = 14;
	localparam int DCC_TAG_W = 4;
	localparam logic [DCC_TAG_W-1:0] DCC_CQ_LAST = 4'hd;
	// dispatch only while at least a full dispatch group still fits
	localparam logic [DCC_TAG_W-1:0] DCC_CQ_SPARE = 4'hc;
	localparam int DCC_NU = 4;
	localparam int DCC_IQ_DEPTH = 4;
	localparam int DCC_IQ_CW = 3;
	localparam logic [DCC_IQ_CW-1:0] DCC_IQ_SPARE = 3'h2;
	localparam int DCC_MUL_LAT = 4;
	localparam int DCC_DIV_CW = 6;
	localparam logic [DCC_DIV_CW-1:0] DCC_DIV_ONE = 6'h01;
	localparam logic [DCC_DIV_CW-1:0] DCC_DIV_LAT [4] = '{6'h04, 6'h0b, 6'h13, 6'h23};

	typedef enum logic [1:0] {
		DCC_U_ALU = 2'h0,
		DCC_U_BR = 2'h1,
		DCC_U_MUL = 2'h2,
		DCC_U_DIV = 2'h3
	} dcc_unit_t;

	// one decode slot from the instruction queue; static hint bits are not carried
	typedef struct packed {
		logic vld;
		dcc_unit_t unit;
		logic [1:0] div_len;
		logic dyn_taken;
	} dcc_slot_t;

	typedef struct packed {
		logic vld;
		logic [DCC_TAG_W-1:0] tag;
	} dcc_tagv_t;

	typedef struct packed {
		logic [1:0] aux;
		logic [DCC_TAG_W-1:0] tag;
	} dcc_iqe_t;

	function automatic logic [DCC_TAG_W-1:0] dcc_tag_inc(input logic [DCC_TAG_W-1:0] t);
		return (t == DCC_CQ_LAST) ? '0 : t + 4'h1;
	endfunction

endpackage

`default_nettype wire

//--- hdl/dcc_mul_pipe.sv
/*
 * four-stage pipelined multiply tracker: carries completion tags through the stages.
 * assumes the caller offers at most one instruction per cycle and flushes on squash.
 */
`default_nettype none

module dcc_mul_pipe import dcc_pkg::*; (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire dcc_tagv_t i_in,
	input wire logic i_flush,
	output dcc_tagv_t o_out
);

	typedef struct packed {
		dcc_tagv_t [DCC_MUL_LAT-1:0] st;
	} dcc_mul_st_t;

	dcc_mul_st_t s_r;
	dcc_mul_st_t s_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// a new entry every cycle; no stage ever stalls
	always_comb begin
		s_nxt = s_r;
		s_nxt.st[0] = i_flush ? '0 : i_in;
		for (int i = 1; i < DCC_MUL_LAT; i++) begin
			s_nxt.st[i] = i_flush ? '0 : s_r.st[i-1];
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_out = s_r.st[DCC_MUL_LAT-1];

	////////////////////////////////////////////////////////////////////////////////
	default clocking dcc_mul_cb @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);

	AST_MUL_LAT: assert property (
		(i_in.vld && !i_flush) ##1 (!i_flush) [*3]
		|=> (o_out.vld && o_out.tag == $past(i_in.tag, 4)))
		else $error("multiply result not out four cycles after entry");

endmodule

`default_nettype wire

//--- hdl/dcc_div_unit.sv
/*
 * multi-cycle divide occupancy tracker: holds one instruction for its whole latency.
 * assumes the caller offers work only while o_idle is high.
 */
`default_nettype none

module dcc_div_unit import dcc_pkg::*; (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire dcc_tagv_t i_in,
	input wire logic [1:0] i_len,
	input wire logic i_flush,
	output logic o_idle,
	output dcc_tagv_t o_done
);

	typedef enum logic [1:0] {
		DCC_DV_IDLE = 2'b01,
		DCC_DV_BUSY = 2'b10
	} dcc_dv_state_t;

	typedef struct packed {
		dcc_dv_state_t state;
		logic [DCC_DIV_CW-1:0] cnt;
		logic [DCC_TAG_W-1:0] tag;
		dcc_tagv_t done;
	} dcc_div_st_t;

	dcc_div_st_t s_r;
	dcc_div_st_t s_nxt;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = '0;
		unique case (s_r.state)
			DCC_DV_IDLE: begin
				if (i_in.vld && !i_flush) begin
					s_nxt.state = DCC_DV_BUSY;
					s_nxt.cnt = DCC_DIV_LAT[i_len];
					s_nxt.tag = i_in.tag;
				end
			end
			DCC_DV_BUSY: begin
				if (i_flush) begin
					s_nxt.state = DCC_DV_IDLE;
				end else if (s_r.cnt == DCC_DIV_ONE) begin
					s_nxt.state = DCC_DV_IDLE;
					s_nxt.done = '{1'b1, s_r.tag};
				end else begin
					s_nxt.cnt = s_r.cnt - DCC_DIV_ONE;
				end
			end
			default: begin
				s_nxt.state = DCC_DV_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_r <= '{DCC_DV_IDLE, '0, '0, '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_idle = (s_r.state == DCC_DV_IDLE);
	assign o_done = s_r.done;

	////////////////////////////////////////////////////////////////////////////////
	default clocking dcc_div_cb @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);

	AST_DIV_HOLD: assert property (
		(i_in.vld && o_idle && !i_flush) |=> (!o_idle) [*3])
		else $error("divide left the execute stage too early");

endmodule

`default_nettype wire

//--- hdl/dcc_dispatch_ctrl.sv
/*
 * dispatch, issue, completion and write back control of a two-wide out-of-order core.
 * assumes in-core synchronous neighbours; results themselves live outside this block.
 */
// What this block does
// - with prediction disabled every branch is reported as not taken.
// - direction comes from the dynamic predictor only, never from static hint bits.
// - a mispredicted branch redirects fetch and squashes younger work when it completes.
// - completion is in order, from the two oldest queue entries only.
// - only finished, exception-free entries complete, and only behind completed older ones.
// - completing an entry removes it from the completion queue in that same step.
// - decode dispatches only while issue queue and completion queue both have room.
// - dispatch writes the issue queue and allocates the completion entry together.
// - execution units report finish; architected state waits for completion.
// - issue reads operands and routes each instruction to its own unit.
// - reservation stations accept work before operands or units are ready.
// - multiply accepts one instruction per cycle and returns each after four cycles.
// - write back follows completion by exactly one cycle.
// - write back results are never dropped by a squash or exception.
// - older results finish writing back before an exception is taken.
// - divide may hold the execute stage for many cycles.
// - an instruction stalls in place while its data or unit is unavailable.
// - completion order is the order in which fetch delivered instructions.
// - at most two instructions dispatch per cycle, branches included.
`default_nettype none

module dcc_dispatch_ctrl import dcc_pkg::*; (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_predict_enable,
	input wire dcc_slot_t [DCC_DISP_W-1:0] i_slot,
	input wire logic [DCC_NU-1:0] i_opnd_ready,
	input wire logic i_alu_exc,
	input wire logic i_br_mispredict,
	output logic o_dq_ready,
	output dcc_tagv_t [DCC_DISP_W-1:0] o_dispatch,
	output logic [DCC_DISP_W-1:0] o_pred_taken,
	output dcc_tagv_t [DCC_NU-1:0] o_issue,
	output dcc_tagv_t [DCC_DISP_W-1:0] o_complete,
	output dcc_tagv_t [DCC_DISP_W-1:0] o_wb,
	output logic o_redirect,
	output logic o_exc_take,
	output logic o_flush
);

	typedef struct packed {
		logic [DCC_CQ_DEPTH-1:0] cq_vld;
		logic [DCC_CQ_DEPTH-1:0] cq_fin;
		logic [DCC_CQ_DEPTH-1:0] cq_exc;
		logic [DCC_CQ_DEPTH-1:0] cq_mis;
		logic [DCC_TAG_W-1:0] cq_head;
		logic [DCC_TAG_W-1:0] cq_tail;
		logic [DCC_TAG_W-1:0] cq_cnt;
		dcc_iqe_t [DCC_NU-1:0][DCC_IQ_DEPTH-1:0] iq;
		logic [DCC_NU-1:0][DCC_IQ_CW-1:0] iq_cnt;
		logic [DCC_NU-1:0] rs_vld;
		dcc_iqe_t [DCC_NU-1:0] rs;
		dcc_tagv_t [1:0] ex;
		logic [1:0] ex_flag;
		logic dq_ready;
		dcc_tagv_t [DCC_DISP_W-1:0] disp;
		logic [DCC_DISP_W-1:0] pred;
		dcc_tagv_t [DCC_NU-1:0] issue;
		dcc_tagv_t [DCC_DISP_W-1:0] comp;
		dcc_tagv_t [DCC_DISP_W-1:0] wb;
		logic redirect;
		logic exc_take;
		logic flush;
	} dcc_ctrl_st_t;

	dcc_ctrl_st_t s_r;
	dcc_ctrl_st_t s_nxt;

	logic [DCC_TAG_W-1:0] h0;
	logic [DCC_TAG_W-1:0] h1;
	logic [DCC_TAG_W-1:0] ptr;
	logic can0;
	logic can1;
	logic exc0;
	logic mis_c;
	logic flush_c;
	logic rdy;
	logic div_idle;
	logic [DCC_NU-1:0] unit_free;
	logic [DCC_NU-1:0] leave;
	logic [1:0] div_len;
	dcc_unit_t u;
	dcc_tagv_t mul_in;
	dcc_tagv_t mul_out;
	dcc_tagv_t div_in;
	dcc_tagv_t div_done;

	////////////////////////////////////////////////////////////////////////////////
	dcc_mul_pipe u_mul (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_in(mul_in),
		.i_flush(flush_c),
		.o_out(mul_out)
	);

	dcc_div_unit u_div (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_in(div_in),
		.i_len(div_len),
		.i_flush(flush_c),
		.o_idle(div_idle),
		.o_done(div_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		u = DCC_U_ALU;
		rdy = 1'b1;

		// completion looks at the two oldest entries only
		h0 = s_r.cq_head;
		h1 = dcc_tag_inc(s_r.cq_head);
		can0 = s_r.cq_vld[h0] && s_r.cq_fin[h0] && !s_r.cq_exc[h0];
		can1 = can0 && !s_r.cq_mis[h0] && s_r.cq_vld[h1] && s_r.cq_fin[h1]
			&& !s_r.cq_exc[h1];
		// the faulting entry waits until nothing older is still in flight to write back
		exc0 = s_r.cq_vld[h0] && s_r.cq_fin[h0] && s_r.cq_exc[h0]
			&& !s_r.comp[0].vld && !s_r.wb[0].vld;
		mis_c = (can0 && s_r.cq_mis[h0]) || (can1 && s_r.cq_mis[h1]);
		flush_c = mis_c || exc0;

		s_nxt.comp[0] = '{can0, h0};
		s_nxt.comp[1] = '{can1, h1};
		s_nxt.wb = s_r.comp;
		s_nxt.redirect = mis_c;
		s_nxt.exc_take = exc0;
		s_nxt.flush = flush_c;
		s_nxt.disp = '0;
		s_nxt.pred = '0;
		s_nxt.issue = '0;

		// finish marks the entry; architected state is untouched until completion
		if (s_r.ex[0].vld) begin
			s_nxt.cq_fin[s_r.ex[0].tag] = 1'b1;
			s_nxt.cq_exc[s_r.ex[0].tag] = s_r.ex_flag[0];
		end
		if (s_r.ex[1].vld) begin
			s_nxt.cq_fin[s_r.ex[1].tag] = 1'b1;
			s_nxt.cq_mis[s_r.ex[1].tag] = s_r.ex_flag[1];
		end
		if (mul_out.vld) begin
			s_nxt.cq_fin[mul_out.tag] = 1'b1;
		end
		if (div_done.vld) begin
			s_nxt.cq_fin[div_done.tag] = 1'b1;
		end

		// retirement is the completion itself
		if (can0) begin
			s_nxt.cq_vld[h0] = 1'b0;
		end
		if (can1) begin
			s_nxt.cq_vld[h1] = 1'b0;
		end
		s_nxt.cq_head = can1 ? dcc_tag_inc(h1) : (can0 ? h1 : h0);
		s_nxt.cq_cnt = s_r.cq_cnt - DCC_TAG_W'(can0) - DCC_TAG_W'(can1);

		// reservation station to unit, issue queue to reservation station
		unit_free = '1;
		unit_free[DCC_U_DIV] = div_idle;
		for (int k = 0; k < DCC_NU; k++) begin
			leave[k] = s_r.rs_vld[k] && i_opnd_ready[k] && unit_free[k];
			if (leave[k]) begin
				s_nxt.rs_vld[k] = 1'b0;
			end
			// the station takes work before its operands are ready
			if ((!s_r.rs_vld[k] || leave[k]) && s_r.iq_cnt[k] != '0) begin
				s_nxt.rs_vld[k] = 1'b1;
				s_nxt.rs[k] = s_r.iq[k][0];
				s_nxt.issue[k] = '{1'b1, s_r.iq[k][0].tag};
				for (int e = 0; e < DCC_IQ_DEPTH - 1; e++) begin
					s_nxt.iq[k][e] = s_r.iq[k][e+1];
				end
				s_nxt.iq_cnt[k] = s_r.iq_cnt[k] - DCC_IQ_CW'(1);
			end
		end

		// each unit gets only its own station's work
		s_nxt.ex[0] = '{leave[DCC_U_ALU], s_r.rs[DCC_U_ALU].tag};
		s_nxt.ex_flag[0] = i_alu_exc;
		s_nxt.ex[1] = '{leave[DCC_U_BR], s_r.rs[DCC_U_BR].tag};
		s_nxt.ex_flag[1] = i_br_mispredict;
		mul_in = '{leave[DCC_U_MUL], s_r.rs[DCC_U_MUL].tag};
		div_in = '{leave[DCC_U_DIV], s_r.rs[DCC_U_DIV].tag};
		div_len = s_r.rs[DCC_U_DIV].aux;

		// dispatch: queue entry and completion entry in one step, in fetch order
		ptr = s_r.cq_tail;
		if (s_r.dq_ready && !flush_c) begin
			for (int k = 0; k < DCC_DISP_W; k++) begin
				if (i_slot[k].vld && i_slot[0].vld) begin
					u = i_slot[k].unit;
					s_nxt.cq_vld[ptr] = 1'b1;
					s_nxt.cq_fin[ptr] = 1'b0;
					s_nxt.cq_exc[ptr] = 1'b0;
					s_nxt.cq_mis[ptr] = 1'b0;
					s_nxt.iq[u][s_nxt.iq_cnt[u]] = '{i_slot[k].div_len, ptr};
					s_nxt.iq_cnt[u] = s_nxt.iq_cnt[u] + DCC_IQ_CW'(1);
					s_nxt.disp[k] = '{1'b1, ptr};
					// static hint bits never reach this point
					s_nxt.pred[k] = i_predict_enable && i_slot[k].dyn_taken;
					s_nxt.cq_cnt = s_nxt.cq_cnt + DCC_TAG_W'(1);
					ptr = dcc_tag_inc(ptr);
				end
			end
		end
		s_nxt.cq_tail = ptr;

		// squash: everything still queued is younger than the flush point
		if (flush_c) begin
			s_nxt.cq_vld = '0;
			s_nxt.cq_cnt = '0;
			s_nxt.cq_head = s_r.cq_tail;
			s_nxt.cq_tail = s_r.cq_tail;
			s_nxt.iq_cnt = '0;
			s_nxt.rs_vld = '0;
			s_nxt.ex = '0;
		end

		// ready is registered, so it must leave room for a full group
		for (int k = 0; k < DCC_NU; k++) begin
			rdy = rdy && (s_nxt.iq_cnt[k] <= DCC_IQ_SPARE);
		end
		s_nxt.dq_ready = rdy && (s_nxt.cq_cnt <= DCC_CQ_SPARE);
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign o_dq_ready = s_r.dq_ready;
	assign o_dispatch = s_r.disp;
	assign o_pred_taken = s_r.pred;
	assign o_issue = s_r.issue;
	assign o_complete = s_r.comp;
	assign o_wb = s_r.wb;
	assign o_redirect = s_r.redirect;
	assign o_exc_take = s_r.exc_take;
	assign o_flush = s_r.flush;

	////////////////////////////////////////////////////////////////////////////////
	default clocking dcc_ctl_cb @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);

	AST_PRED_OFF: assert property (
		(s_r.dq_ready && !flush_c && i_slot[0].vld && !i_predict_enable)
		|=> (o_dispatch[0].vld && !o_pred_taken[0]))
		else $error("branch predicted taken with prediction disabled");

	AST_PRED_DYN: assert property (
		(s_r.dq_ready && !flush_c && i_slot[0].vld && i_predict_enable)
		|=> (o_pred_taken[0] == $past(i_slot[0].dyn_taken)))
		else $error("prediction not taken from the dynamic predictor");

	AST_REDIRECT: assert property (
		o_redirect |-> (o_flush && s_r.cq_cnt == '0))
		else $error("redirect without squash of younger work");

	AST_COMP_ORDER: assert property (
		o_complete[1].vld |-> (o_complete[0].vld
		&& o_complete[1].tag == dcc_tag_inc(o_complete[0].tag)))
		else $error("completion out of program order");

	AST_COMP_FIN: assert property (
		(s_r.cq_vld[s_r.cq_head] && !s_r.cq_fin[s_r.cq_head]) |=> !o_complete[0].vld)
		else $error("unfinished entry completed");

	AST_RETIRE: assert property (
		(o_complete[0].vld && !o_dispatch[0].vld && !o_dispatch[1].vld)
		|-> !s_r.cq_vld[o_complete[0].tag])
		else $error("completed entry still in the completion queue");

	AST_DISP_PAIR: assert property (
		o_dispatch[1].vld |-> (o_dispatch[0].vld
		&& o_dispatch[1].tag == dcc_tag_inc(o_dispatch[0].tag)))
		else $error("second dispatch slot used alone or out of order");

	AST_RS_STALL: assert property (
		(s_r.rs_vld[DCC_U_ALU] && !i_opnd_ready[DCC_U_ALU] && !flush_c)
		|=> (s_r.rs_vld[DCC_U_ALU] && s_r.rs[DCC_U_ALU] == $past(s_r.rs[DCC_U_ALU])))
		else $error("instruction left the station without operands");

	AST_WB_NEXT: assert property (
		o_complete[0].vld |=> (o_wb[0].vld && o_wb[0].tag == $past(o_complete[0].tag)))
		else $error("write back not in the cycle after completion");

	AST_WB_KEEP: assert property (
		(o_complete[1].vld && o_flush) |=> o_wb[1].vld)
		else $error("write back dropped by a squash");

	AST_EXC_AFTER_WB: assert property (
		o_exc_take |-> (!o_wb[0].vld && !$past(o_wb[0].vld)))
		else $error("exception taken before older write back");

	AST_FLUSH_EMPTY: assert property (
		o_flush |-> (s_r.cq_vld == '0 && s_r.rs_vld == '0 && s_r.iq_cnt == '0))
		else $error("queues not emptied by a flush");

	AST_DQ_HOLD: assert property (
		!o_dq_ready |=> (!o_dispatch[0].vld && !o_dispatch[1].vld))
		else $error("dispatch taken while not ready");

	AST_CQ_ALLOC: assert property (
		o_dispatch[0].vld
		|-> (s_r.cq_vld[o_dispatch[0].tag] && !s_r.cq_fin[o_dispatch[0].tag]))
		else $error("dispatch without a fresh completion entry");

	AST_ISSUE_ROUTE: assert property (
		(o_issue[DCC_U_ALU].vld && !o_flush)
		|-> (s_r.rs_vld[DCC_U_ALU] && s_r.rs[DCC_U_ALU].tag == o_issue[DCC_U_ALU].tag))
		else $error("issued instruction not held by its own station");

	AST_RS_EARLY: assert property (
		(!s_r.rs_vld[DCC_U_ALU] && s_r.iq_cnt[DCC_U_ALU] != '0 && !i_opnd_ready[DCC_U_ALU]
		&& !flush_c) |=> s_r.rs_vld[DCC_U_ALU])
		else $error("station refused work whose operands were not ready");

	AST_DIV_BLOCK: assert property (
		(s_r.rs_vld[DCC_U_DIV] && !div_idle && !flush_c) |=> s_r.rs_vld[DCC_U_DIV])
		else $error("divide station released while the divider was busy");

	AST_TAIL_ORDER: assert property (
		(o_dispatch[0].vld && !o_dispatch[1].vld)
		|-> (s_r.cq_tail == dcc_tag_inc(o_dispatch[0].tag)))
		else $error("completion tail does not follow dispatch order");

endmodule

`default_nettype wire

//--- test/dcc_dispatch_ctrl_bench.sv
/*
 * self-checking bench for dcc_dispatch_ctrl: one hand-written task per scenario.
 * assumes dcc_pkg and the design files are compiled before this file.
 */
`default_nettype none

module dcc_dispatch_ctrl_bench import dcc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock, arst_n, pen, exc, misp, dq_ready, redir, exc_take, flush;
	dcc_slot_t [DCC_DISP_W-1:0] slot;
	logic [DCC_NU-1:0] rdy;
	logic [DCC_DISP_W-1:0] pred;
	dcc_tagv_t [DCC_DISP_W-1:0] disp, cmp, wb;
	dcc_tagv_t [DCC_NU-1:0] iss;
	int miscompares = 0;
	int compares = 0;

	dcc_dispatch_ctrl dut (
		.i_clock(clock),
		.i_arst_n(arst_n),
		.i_predict_enable(pen),
		.i_slot(slot),
		.i_opnd_ready(rdy),
		.i_alu_exc(exc),
		.i_br_mispredict(misp),
		.o_dq_ready(dq_ready),
		.o_dispatch(disp),
		.o_pred_taken(pred),
		.o_issue(iss),
		.o_complete(cmp),
		.o_wb(wb),
		.o_redirect(redir),
		.o_exc_take(exc_take),
		.o_flush(flush)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_tag(string what, dcc_tagv_t exp, dcc_tagv_t got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(string what, logic exp, logic got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	function automatic dcc_slot_t mk(dcc_unit_t u, logic [1:0] d = 2'h0, logic t = 1'h0);
		return {1'h1, u, d, t};
	endfunction

	// every scenario starts from reset so that tags begin at zero
	task automatic do_reset();
		arst_n = 1'h0;
		slot = '0;
		rdy = 4'hf;
		exc = 1'h0;
		misp = 1'h0;
		pen = 1'h1;
		repeat (5) @(negedge clock);
		arst_n = 1'h1;
		@(negedge clock);
	endtask

	// returns in the cycle after the taking edge, where o_dispatch is shown
	task automatic send(dcc_slot_t s0, dcc_slot_t s1);
		int n;
		n = 0;
		// an edge between calls keeps slot from being driven twice in one step
		@(negedge clock);
		while (dq_ready !== 1'h1 && n < 50) begin
			@(negedge clock);
			n++;
		end
		chk_bit("dq_ready", 1'h1, dq_ready);
		slot = {s1, s0};
		@(negedge clock);
		slot = '0;
	endtask

	task automatic wait_ev(bit sel, int lim, output int n);
		n = 0;
		while ((sel ? exc_take : cmp[0].vld) !== 1'h1 && n < lim) begin
			@(negedge clock);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_walk();
		int n;
		do_reset();
		send(mk(DCC_U_ALU), '0);
		chk_tag("dispatch0", {1'h1, 4'h0}, disp[0]);
		chk_tag("dispatch1", '0, disp[1]);
		@(negedge clock);
		chk_tag("issue alu", {1'h1, 4'h0}, iss[0]);
		wait_ev(0, 20, n);
		chk_bit("alu latency", 1'h1, n == 3);
		chk_tag("complete0", {1'h1, 4'h0}, cmp[0]);
		chk_tag("wb early", '0, wb[0]);
		@(negedge clock);
		chk_tag("wb0", {1'h1, 4'h0}, wb[0]);
		chk_bit("complete once", 1'h0, cmp[0].vld);
		$display("walk done");
	endtask

	task automatic t_pair();
		int n;
		do_reset();
		send('0, mk(DCC_U_ALU));
		chk_tag("lone slot1", '0, disp[1]);
		send(mk(DCC_U_ALU), mk(DCC_U_BR));
		chk_tag("pair0", {1'h1, 4'h0}, disp[0]);
		chk_tag("pair1", {1'h1, 4'h1}, disp[1]);
		wait_ev(0, 20, n);
		chk_tag("older first", {1'h1, 4'h0}, cmp[0]);
		chk_tag("younger second", {1'h1, 4'h1}, cmp[1]);
		$display("pair done");
	endtask

	task automatic t_pred();
		do_reset();
		for (int i = 0; i < 4; i++) begin
			pen = i[1];
			send(mk(DCC_U_BR, 2'h0, i[0]), mk(DCC_U_BR, 2'h0, ~i[0]));
			chk_bit("pred0", i[1] & i[0], pred[0]);
			chk_bit("pred1", i[1] & ~i[0], pred[1]);
		end
		$display("predict done");
	endtask

	task automatic t_misp();
		int n;
		do_reset();
		misp = 1'h1;
		send(mk(DCC_U_BR), mk(DCC_U_ALU));
		wait_ev(0, 20, n);
		chk_tag("branch done", {1'h1, 4'h0}, cmp[0]);
		chk_bit("wrong path held", 1'h0, cmp[1].vld);
		chk_bit("redirect", 1'h1, redir);
		chk_bit("flush", 1'h1, flush);
		misp = 1'h0;
		@(negedge clock);
		chk_tag("wb kept", {1'h1, 4'h0}, wb[0]);
		wait_ev(0, 10, n);
		chk_bit("squashed quiet", 1'h1, n == 10);
		$display("mispredict done");
	endtask

	task automatic t_exc();
		int n;
		do_reset();
		exc = 1'h1;
		send(mk(DCC_U_BR), mk(DCC_U_ALU));
		wait_ev(0, 20, n);
		chk_tag("older done", {1'h1, 4'h0}, cmp[0]);
		chk_bit("faulting held", 1'h0, cmp[1].vld);
		chk_bit("no early take", 1'h0, exc_take);
		@(negedge clock);
		chk_tag("older wb", {1'h1, 4'h0}, wb[0]);
		chk_bit("take waits wb", 1'h0, exc_take);
		wait_ev(1, 10, n);
		chk_bit("take", 1'h1, exc_take);
		chk_bit("take flush", 1'h1, flush);
		chk_bit("no complete at take", 1'h0, cmp[0].vld);
		exc = 1'h0;
		$display("exception done");
	endtask

	task automatic t_mul();
		int n;
		do_reset();
		send(mk(DCC_U_MUL), mk(DCC_U_MUL));
		wait_ev(0, 20, n);
		chk_bit("mul latency", 1'h1, n >= 7 && n <= 8);
		chk_tag("mul first", {1'h1, 4'h0}, cmp[0]);
		@(negedge clock);
		chk_tag("mul next cycle", {1'h1, 4'h1}, cmp[0]);
		$display("multiply done");
	endtask

	task automatic t_stall();
		int n, got;
		do_reset();
		rdy = 4'h0;
		send(mk(DCC_U_ALU), '0);
		@(negedge clock);
		chk_tag("station takes", {1'h1, 4'h0}, iss[0]);
		wait_ev(0, 12, n);
		chk_bit("held", 1'h1, n == 12);
		rdy = 4'h1;
		wait_ev(0, 10, n);
		chk_bit("released", 1'h1, n == 3);
		// fill the alu queue with nothing draining; only queue plus station may be taken
		rdy = 4'h0;
		got = 0;
		for (int i = 0; i < 10; i++) begin
			slot = {mk(DCC_U_ALU), mk(DCC_U_ALU)};
			@(negedge clock);
			got += int'(disp[0].vld === 1'h1) + int'(disp[1].vld === 1'h1);
		end
		slot = '0;
		chk_bit("refusing", 1'h0, dq_ready);
		chk_bit("no overfill", 1'h1, got <= DCC_IQ_DEPTH + 1);
		rdy = 4'hf;
		repeat (10) @(negedge clock);
		chk_bit("ready again", 1'h1, dq_ready);
		$display("stall done");
	endtask

	task automatic t_div();
		int n;
		for (int i = 0; i < 4; i++) begin
			do_reset();
			// the second divide waits in its station while the first is busy
			send(mk(DCC_U_DIV, i[1:0]), mk(DCC_U_DIV, i[1:0]));
			wait_ev(0, 60, n);
			chk_bit("div length", 1'h1, n == int'(DCC_DIV_LAT[i]) + 4);
		end
		$display("divide done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'h0;
		forever #20 clock = ~clock;
	end

	// the scenarios need well under a thousand cycles; the margin is generous
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		finish_test();
	end

	initial begin
		arst_n = 1'h0;
		slot = '0;
		rdy = 4'hf;
		exc = 1'h0;
		misp = 1'h0;
		pen = 1'h1;
		t_walk();
		t_pair();
		t_pred();
		t_misp();
		t_exc();
		t_mul();
		t_stall();
		t_div();
		finish_test();
	end
endmodule

`default_nettype wire
